/* logic/iex_pkg.sv */
package iex_pkg;
	localparam int WORD_W  = 24;
	localparam int ADDR_W  = 15;
	localparam int CHAR_W  = 17;
	localparam int CODE_W  = 12;
	localparam int DIG_N   = 12;
	localparam int E_W     = 48;
	localparam int CH_N    = 8;
	localparam int CH_W    = 3;
	localparam int LEN_W   = 4;

	localparam logic [5:0] OP_HALT    = 6'h00;
	localparam logic [5:0] OP_JUMP    = 6'h03;
	localparam logic [5:0] OP_SKE     = 6'h04;
	localparam logic [5:0] OP_SKG     = 6'h05;
	localparam logic [5:0] OP_ENTER_CHAR_ADDRESS    = 6'h09;
	localparam logic [5:0] OP_ENTER   = 6'h0C;
	localparam logic [5:0] OP_INCR    = 6'h0D;
	localparam logic [5:0] OP_AND     = 6'h0F;
	localparam logic [5:0] OP_ADD     = 6'h18;
	localparam logic [5:0] OP_DIV     = 6'h29;
	localparam logic [5:0] OP_REGADD  = 6'h2B;
	localparam logic [5:0] OP_DDIV    = 6'h2F;
	localparam logic [5:0] OP_BCDADD  = 6'h36;
	localparam logic [5:0] OP_EJUMP   = 6'h38;
	localparam logic [5:0] OP_IO      = 6'h3F;

	localparam logic [2:0] SUB_CONN   = 3'h0;
	localparam logic [2:0] SUB_EXS    = 3'h2;
	localparam logic [2:0] SUB_INS    = 3'h3;
	localparam logic [2:0] SUB_INTERRUPT_LINE_SENSE   = 3'h4;
	localparam logic [2:0] SUB_GRP5   = 3'h5;
	localparam logic [2:0] SUB_GRP7   = 3'h7;
	localparam logic [2:0] SUB_FCLR   = 3'h0;
	localparam logic [2:0] SUB_INTERRUPT_DISABLE_OP   = 3'h3;
	localparam logic [2:0] SUB_INTERRUPT_ENABLE_OP   = 3'h4;
	localparam logic [2:0] SUB_LO4    = 3'h4;

	localparam int FAULT_DIV_BIT = 0;
	localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;

	typedef enum logic [0:0] {
		IEX_RUN  = 1'b0,
		IEX_HALT = 1'b1
	} iex_state_t;
endpackage

/* logic/iex_add_if.sv */
`timescale 1ns/10ps
interface iex_add_if;
	logic [iex_pkg::WORD_W-1:0] a;
	logic [iex_pkg::WORD_W-1:0] b;
	logic [iex_pkg::WORD_W-1:0] sum;
	modport user (output a, output b, input sum);
	modport adder (input a, input b, output sum);
endinterface

/* logic/iex_ones_add.sv */
`timescale 1ns/10ps
module iex_ones_add (
	iex_add_if.adder add
);
	logic [iex_pkg::WORD_W:0] raw;

	assign raw = {1'b0, add.a} + {1'b0, add.b};
	// End-around carry keeps one's-complement modulus 2^24-1
	assign add.sum = raw[iex_pkg::WORD_W-1:0] + {{(iex_pkg::WORD_W-1){1'b0}}, raw[iex_pkg::WORD_W]}; // RULE_23
endmodule

/* logic/iex_exec.sv */
`timescale 1ns/10ps
// Operation
// (RULE_01) Code 30 adds storage word to first register.
// (RULE_02) Code 53.04 adds auxiliary to first register, sum in first.
// (RULE_03) Add-to-index sign-extends index, adds first register, writes index.
// (RULE_04) Code 66 adds up to twelve BCD digits into work word.
// (RULE_05) Logical product immediate; 17.6/17.7 zero-fill, 17.4/17.5 sign-extend.
// (RULE_06) Codes 03.0-03.3 test first register against zero, jump on success.
// (RULE_07) Codes 03.4-03.7 compare first with auxiliary, jump on success.
// (RULE_08) Skip on equal immediate; 04.6 low 15 bits, 04.4 sign-extended.
// (RULE_09) Skip when first register not less; 05.4 sign-extends, 05.6 not.
// (RULE_10) Enter 17-bit address; 11.0 zero-fills, 11.4 sign-extends.
// (RULE_11) Load immediate clears register; 14.4/14.5 extend sign.
// (RULE_12) 70.4 jumps on zero work word, 70.5 on negative.
// (RULE_13) 70.6 jumps when work word overflowed.
// (RULE_14) 00.0 halts; restart fetches at halt target address.
// (RULE_15) Code 51 divides first register; quotient first, remainder auxiliary.
// (RULE_16) Code 57 divides triple group; fault abandons and advances.
// (RULE_17) 77.0 rejects if busy, else strobes connect code and skips.
// (RULE_18) 77.2 copy form loads status low, interrupt mask high.
// (RULE_19) 77.2/77.3 sense: match continues, no match skips.
// (RULE_20) 77.4: active masked interrupt continues, otherwise skips.
// (RULE_21) 77.73 disables interrupts; 77.74 enables after one more instruction.
// (RULE_22) 77.50 clears only selected interrupt faults.
// (RULE_23) Single-word arithmetic is one's complement with end-around carry.
// (RULE_24) Instructions without skip or jump advance one location.
module iex_exec #(
	parameter int CH_N = iex_pkg::CH_N
) (
	input  wire logic                            core_clk,
	input  wire logic                            nrst,
	input  wire logic                            instr_valid,
	input  wire logic [iex_pkg::WORD_W-1:0]      instr_word,
	input  wire logic [iex_pkg::WORD_W-1:0]      mem_word,
	input  wire logic [iex_pkg::WORD_W-1:0]      mem_word2,
	input  wire logic [iex_pkg::E_W-1:0]         bcd_field,
	input  wire logic [iex_pkg::LEN_W-1:0]       len_count,
	input  wire logic                            restart,
	input  wire logic [CH_N-1:0]                 chan_busy,
	input  wire logic [iex_pkg::CODE_W-1:0]      ext_status,
	input  wire logic [iex_pkg::CODE_W-1:0]      int_status,
	input  wire logic [iex_pkg::CODE_W-1:0]      int_lines,
	input  wire logic [iex_pkg::CODE_W-1:0]      int_mask,
	input  wire logic [iex_pkg::CODE_W-1:0]      fault_set,
	output logic                                 instr_ready,
	output logic [iex_pkg::CH_W-1:0]             chan_addr,
	output logic [iex_pkg::ADDR_W-1:0]           pc_reg,
	output logic [iex_pkg::WORD_W-1:0]           acc_reg,
	output logic [iex_pkg::WORD_W-1:0]           aux_reg,
	output logic [iex_pkg::E_W-1:0]              bcd_reg,
	output logic [3*iex_pkg::ADDR_W-1:0]         index_reg,
	output logic                                 bcd_ovf_reg,
	output logic                                 halted,
	output logic [iex_pkg::CODE_W-1:0]           conn_code_reg,
	output logic [iex_pkg::CH_W-1:0]             conn_chan_reg,
	output logic                                 conn_strobe_reg,
	output logic [iex_pkg::CODE_W-1:0]           fault_reg,
	output logic                                 int_enable_reg,
	output logic                                 int_take
);
	localparam int W  = iex_pkg::WORD_W;
	localparam int AW = iex_pkg::ADDR_W;
	localparam int EW = iex_pkg::E_W;

	iex_add_if add_bus ();
	iex_ones_add u_add (
		.add (add_bus.adder)
	);

	iex_pkg::iex_state_t state_reg;
	logic                int_hold_reg;

	logic [5:0]    op;
	logic [2:0]    sub;
	logic [2:0]    sub2;
	logic [AW-1:0] y;
	logic [W-1:0]  y_sx;
	logic [W-1:0]  y_zx;
	logic [1:0]    bsel;
	logic          fire;
	logic [AW-1:0] idx_cur;

	assign op   = instr_word[23:18];
	assign sub  = instr_word[17:15];
	assign sub2 = instr_word[14:12];
	assign y    = instr_word[AW-1:0];
	assign y_sx = {{(W-AW){y[AW-1]}}, y};
	assign y_zx = {{(W-AW){1'b0}}, y};
	assign bsel = sub[1:0];
	assign chan_addr = sub2;
	assign halted = (state_reg == iex_pkg::IEX_HALT);
	assign instr_ready = !halted;
	assign fire = instr_valid && !halted;
	// Three slots packed from bit 0; b=0 names no index register
	assign idx_cur = (bsel == 2'h0) ? '0 : index_reg[(bsel - 2'h1)*AW +: AW];

	// One's-complement value as a two's-complement number for ordering
	function automatic logic signed [W:0] oc_val(input logic [W-1:0] w);
		oc_val = w[W-1] ? -$signed({1'b0, ~w}) : $signed({1'b0, w});
	endfunction

	function automatic logic oc_ge(input logic [W-1:0] a, input logic [W-1:0] b);
		oc_ge = oc_val(a) >= oc_val(b);
	endfunction

	function automatic logic oc_zero(input logic [W-1:0] a);
		oc_zero = (a == '0) || (a == '1);
	endfunction

	// Adder operand steering
	always_comb begin
		add_bus.a = acc_reg;
		add_bus.b = iex_pkg::WORD_RST;
		if (op == iex_pkg::OP_ADD) begin
			add_bus.b = mem_word; // RULE_01
		end else if (op == iex_pkg::OP_REGADD && sub == 3'h0) begin
			add_bus.b = aux_reg; // RULE_02
		end else if (op == iex_pkg::OP_REGADD) begin
			add_bus.b = {{(W-AW){idx_cur[AW-1]}}, idx_cur}; // RULE_03
		end else if (op == iex_pkg::OP_INCR) begin
			add_bus.a = sub[0] ? aux_reg : acc_reg;
			add_bus.b = sub[1] ? y_zx : y_sx;
		end
	end

	// Dividers: magnitudes divided, signs applied afterwards
	logic [W-1:0]      sd_na;
	logic [W-1:0]      sd_nm;
	logic [W-1:0]      sd_q;
	logic [W-1:0]      sd_r;
	logic              sd_fault;
	logic [3*W-1:0]    dd_n;
	logic [2*W-1:0]    dd_d;
	logic [3*W-1:0]    dd_q;
	logic [2*W-1:0]    dd_r;
	logic              dd_fault;
	logic              dd_neg;

	always_comb begin
		sd_na = acc_reg[W-1] ? ~acc_reg : acc_reg;
		sd_nm = mem_word[W-1] ? ~mem_word : mem_word;
		sd_fault = (sd_nm == '0) || ((sd_na / sd_nm) > {1'b0, {(W-1){1'b1}}});
		sd_q = '0;
		sd_r = '0;
		if (!sd_fault) begin
			sd_q = sd_na / sd_nm;
			sd_r = sd_na % sd_nm;
		end
		if (acc_reg[W-1] ^ mem_word[W-1]) begin
			sd_q = ~sd_q;
		end
		if (acc_reg[W-1]) begin
			sd_r = ~sd_r;
		end
	end

	always_comb begin
		dd_neg = acc_reg[W-1];
		dd_n = {acc_reg, aux_reg, bcd_reg[W-1:0]};
		if (dd_neg) begin
			dd_n = ~dd_n;
		end
		dd_d = {mem_word, mem_word2};
		if (mem_word[W-1]) begin
			dd_d = ~dd_d;
		end
		dd_fault = (dd_d == '0);
		dd_q = '0;
		dd_r = '0;
		if (!dd_fault) begin
			dd_q = dd_n / {{W{1'b0}}, dd_d};
			dd_r = 48'(dd_n % {{W{1'b0}}, dd_d});
		end
		dd_fault = dd_fault || (dd_q[3*W-1:2*W-1] != '0);
		if (dd_neg ^ mem_word[W-1]) begin
			dd_q = ~dd_q;
		end
		if (dd_neg) begin
			dd_r = ~dd_r;
		end
	end

	// BCD field add, digit-serial ripple of decimal carries
	logic [EW-1:0] bcd_opnd;
	logic [EW-1:0] bcd_sum;
	logic [iex_pkg::DIG_N:0] bcd_c;
	logic [4:0]    dig_raw [iex_pkg::DIG_N];

	// Field arrives MSD-first left justified; align its last digit to digit 0
	assign bcd_opnd = bcd_field >> (7'(4) * (7'(iex_pkg::DIG_N) - 7'(len_count))); // RULE_04
	assign bcd_c[0] = 1'b0;
	for (genvar g = 0; g < iex_pkg::DIG_N; g++) begin : g_dig
		assign dig_raw[g] = 5'(bcd_reg[4*g +: 4]) + 5'(bcd_opnd[4*g +: 4]) + 5'(bcd_c[g]);
		assign bcd_c[g+1] = dig_raw[g] > 5'h09;
		assign bcd_sum[4*g +: 4] = bcd_c[g+1] ? 4'(dig_raw[g] - 5'h0A) : dig_raw[g][3:0];
	end

	// Branch decision
	logic [AW-1:0] pc_next;
	logic          take_jump;
	logic          take_skip;
	logic          conn_ok;
	logic [iex_pkg::CODE_W-1:0] xmask;

	assign xmask = instr_word[iex_pkg::CODE_W-1:0];
	assign conn_ok = !chan_busy[chan_addr];

	always_comb begin
		take_jump = 1'b0;
		take_skip = 1'b0;
		unique case (op)
			iex_pkg::OP_JUMP: begin
				unique case (sub)
					3'h0: take_jump = oc_zero(acc_reg); // RULE_06
					3'h1: take_jump = !oc_zero(acc_reg);
					3'h2: take_jump = !acc_reg[W-1];
					3'h3: take_jump = acc_reg[W-1];
					3'h4: take_jump = oc_val(acc_reg) == oc_val(aux_reg); // RULE_07
					3'h5: take_jump = oc_val(acc_reg) != oc_val(aux_reg);
					3'h6: take_jump = oc_ge(acc_reg, aux_reg);
					3'h7: take_jump = !oc_ge(acc_reg, aux_reg);
				endcase
			end
			iex_pkg::OP_SKE: begin
				if (sub == 3'h6) begin
					take_skip = acc_reg[AW-1:0] == y; // RULE_08
				end else if (sub == 3'h4) begin
					take_skip = acc_reg == y_sx;
				end
			end
			iex_pkg::OP_SKG: begin
				if (sub == 3'h6) begin
					take_skip = oc_ge(acc_reg, y_zx); // RULE_09
				end else if (sub == 3'h4) begin
					take_skip = oc_ge(acc_reg, y_sx);
				end
			end
			iex_pkg::OP_EJUMP: begin
				if (sub == 3'h4) begin
					take_jump = bcd_reg == '0; // RULE_12
				end else if (sub == 3'h5) begin
					take_jump = bcd_reg[EW-1];
				end else if (sub == 3'h6) begin
					take_jump = bcd_ovf_reg; // RULE_13
				end
			end
			iex_pkg::OP_IO: begin
				unique case (sub)
					iex_pkg::SUB_CONN: take_skip = conn_ok; // RULE_17
					iex_pkg::SUB_EXS:  take_skip = (xmask != '0) && ((ext_status & xmask) == '0); // RULE_19
					iex_pkg::SUB_INS:  take_skip = (xmask != '0) && ((int_status & xmask) == '0);
					iex_pkg::SUB_INTERRUPT_LINE_SENSE: take_skip = (int_lines & int_mask) == '0; // RULE_20
					default:           take_skip = 1'b0;
				endcase
			end
			default: take_skip = 1'b0;
		endcase
		if (take_jump) begin
			pc_next = y;
		end else if (take_skip) begin
			pc_next = pc_reg + 15'h0002;
		end else begin
			pc_next = pc_reg + 15'h0001; // RULE_24
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pc_reg <= '0;
		end else if (fire && op == iex_pkg::OP_HALT && sub == 3'h0) begin
			pc_reg <= y; // RULE_14
		end else if (fire) begin
			pc_reg <= pc_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= iex_pkg::IEX_RUN;
		end else if (fire && op == iex_pkg::OP_HALT && sub == 3'h0) begin
			state_reg <= iex_pkg::IEX_HALT; // RULE_14
		end else if (restart) begin
			state_reg <= iex_pkg::IEX_RUN;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			acc_reg <= iex_pkg::WORD_RST;
		end else if (fire) begin
			unique case (op)
				iex_pkg::OP_ADD: acc_reg <= add_bus.sum; // RULE_01
				iex_pkg::OP_REGADD: if (sub == 3'h0) acc_reg <= add_bus.sum; // RULE_02
				iex_pkg::OP_INCR: if (!sub[0] && sub[2]) acc_reg <= add_bus.sum; // RULE_23
				iex_pkg::OP_AND: begin
					if (sub == 3'h6) acc_reg <= acc_reg & y_zx; // RULE_05
					else if (sub == 3'h4) acc_reg <= acc_reg & y_sx;
				end
				iex_pkg::OP_ENTER: begin
					if (sub == 3'h6) acc_reg <= y_zx; // RULE_11
					else if (sub == 3'h4) acc_reg <= y_sx;
				end
				iex_pkg::OP_ENTER_CHAR_ADDRESS: acc_reg <= sub[2] ? {{(W-iex_pkg::CHAR_W){instr_word[16]}}, instr_word[16:0]}
					: {{(W-iex_pkg::CHAR_W){1'b0}}, instr_word[16:0]}; // RULE_10
				iex_pkg::OP_DIV: if (!sd_fault) acc_reg <= sd_q; // RULE_15
				iex_pkg::OP_DDIV: if (!dd_fault) acc_reg <= dd_q[2*W-1:W]; // RULE_16
				iex_pkg::OP_IO: begin
					if (sub == iex_pkg::SUB_EXS && xmask == '0) acc_reg <= {int_mask, ext_status}; // RULE_18
					else if (sub == iex_pkg::SUB_INS && xmask == '0) acc_reg <= {int_mask, int_status};
				end
				default: acc_reg <= acc_reg;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			aux_reg <= iex_pkg::WORD_RST;
		end else if (fire) begin
			unique case (op)
				iex_pkg::OP_INCR: if (sub[0] && sub[2]) aux_reg <= add_bus.sum;
				iex_pkg::OP_AND: begin
					if (sub == 3'h7) aux_reg <= aux_reg & y_zx; // RULE_05
					else if (sub == 3'h5) aux_reg <= aux_reg & y_sx;
				end
				iex_pkg::OP_ENTER: begin
					if (sub == 3'h7) aux_reg <= y_zx; // RULE_11
					else if (sub == 3'h5) aux_reg <= y_sx;
				end
				iex_pkg::OP_DIV: if (!sd_fault) aux_reg <= sd_r; // RULE_15
				iex_pkg::OP_DDIV: if (!dd_fault) aux_reg <= dd_q[W-1:0]; // RULE_16
				default: aux_reg <= aux_reg;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			bcd_reg <= '0;
			bcd_ovf_reg <= 1'b0;
		end else if (fire && op == iex_pkg::OP_BCDADD) begin
			bcd_reg <= bcd_sum; // RULE_04
			bcd_ovf_reg <= bcd_c[iex_pkg::DIG_N];
		end else if (fire && op == iex_pkg::OP_DDIV && !dd_fault) begin
			bcd_reg <= {dd_r[2*W-1] ? {(EW-W){1'b1}} : {(EW-W){1'b0}}, dd_r[W-1:0]}; // RULE_16
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			index_reg <= '0;
		end else if (fire && op == iex_pkg::OP_REGADD && sub[2] && bsel != 2'h0 && sub2 == iex_pkg::SUB_LO4) begin
			index_reg[(bsel - 2'h1)*AW +: AW] <= add_bus.sum[AW-1:0]; // RULE_03
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			conn_strobe_reg <= 1'b0;
			conn_code_reg <= '0;
			conn_chan_reg <= '0;
		end else begin
			conn_strobe_reg <= fire && op == iex_pkg::OP_IO && sub == iex_pkg::SUB_CONN && conn_ok; // RULE_17
			if (fire && op == iex_pkg::OP_IO && sub == iex_pkg::SUB_CONN && conn_ok) begin
				conn_code_reg <= xmask;
				conn_chan_reg <= chan_addr;
			end
		end
	end

	logic fclr;
	logic div_flt;

	assign fclr = fire && op == iex_pkg::OP_IO && sub == iex_pkg::SUB_GRP5 && sub2 == iex_pkg::SUB_FCLR;
	assign div_flt = fire && ((op == iex_pkg::OP_DIV && sd_fault) || (op == iex_pkg::OP_DDIV && dd_fault));

	// New faults win over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			fault_reg <= '0;
		end else begin
			fault_reg <= (fault_reg & ~(fclr ? xmask : '0)) | fault_set // RULE_22
				| (div_flt ? iex_pkg::CODE_W'(1 << iex_pkg::FAULT_DIV_BIT) : '0);
		end
	end

	// Hold-off lets exactly one instruction finish after enable
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			int_enable_reg <= 1'b0;
			int_hold_reg <= 1'b0;
		end else if (fire && op == iex_pkg::OP_IO && sub == iex_pkg::SUB_GRP7 && sub2 == iex_pkg::SUB_INTERRUPT_DISABLE_OP) begin
			int_enable_reg <= 1'b0; // RULE_21
			int_hold_reg <= 1'b0;
		end else if (fire && op == iex_pkg::OP_IO && sub == iex_pkg::SUB_GRP7 && sub2 == iex_pkg::SUB_INTERRUPT_ENABLE_OP) begin
			int_enable_reg <= 1'b1; // RULE_21
			int_hold_reg <= 1'b1;
		end else if (fire) begin
			int_hold_reg <= 1'b0;
		end
	end

	assign int_take = int_enable_reg && !int_hold_reg && ((int_lines & int_mask) != '0); // RULE_21
endmodule

/* testbench/iex_chan_model.sv */
`timescale 1ns/10ps
module iex_chan_model #(
	parameter int CH_N = iex_pkg::CH_N
) (
	input  wire logic                       core_clk,
	input  wire logic                       nrst,
	input  wire logic                       conn_strobe_reg,
	input  wire logic [iex_pkg::CH_W-1:0]   conn_chan_reg,
	input  wire logic [iex_pkg::CODE_W-1:0] conn_code_reg,
	input  wire logic [iex_pkg::CH_W-1:0]   chan_addr,
	output logic      [CH_N-1:0]            chan_busy,
	output logic      [iex_pkg::CODE_W-1:0] ext_status
);
	logic [iex_pkg::CODE_W-1:0] code_reg;

	// Code taken on the strobe alone; channel stays busy until reset
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			chan_busy <= '0;
			code_reg  <= 12'h000;
		end else if (conn_strobe_reg) begin
			chan_busy[conn_chan_reg] <= 1'b1;
			code_reg                 <= conn_code_reg;
		end
	end

	// An idle channel reports no status
	assign ext_status = chan_busy[chan_addr] ? code_reg : 12'h000;
endmodule

/* testbench/iex_exec_chk.sv */
`timescale 1ns/10ps
module iex_exec_chk #(
	parameter int CH_N = iex_pkg::CH_N
) (
	input wire logic                         core_clk,
	input wire logic                         nrst,
	input wire logic                         instr_valid,
	input wire logic [iex_pkg::WORD_W-1:0]   instr_word,
	input wire logic [iex_pkg::WORD_W-1:0]   mem_word,
	input wire logic                         restart,
	input wire logic [CH_N-1:0]              chan_busy,
	input wire logic [iex_pkg::CODE_W-1:0]   fault_set,
	input wire logic                         instr_ready,
	input wire logic [iex_pkg::CH_W-1:0]     chan_addr,
	input wire logic [iex_pkg::ADDR_W-1:0]   pc_reg,
	input wire logic [iex_pkg::WORD_W-1:0]   acc_reg,
	input wire logic                         halted,
	input wire logic [iex_pkg::CODE_W-1:0]   conn_code_reg,
	input wire logic                         conn_strobe_reg,
	input wire logic [iex_pkg::CODE_W-1:0]   fault_reg,
	input wire logic                         int_enable_reg,
	input wire logic                         int_take
);
	logic        tk;
	logic        io;
	logic [5:0]  op;
	logic [2:0]  s1;
	logic [2:0]  s2;
	logic [24:0] raw;
	logic [23:0] oc_sum;

	assign tk = instr_valid && instr_ready;
	assign op = instr_word[23:18];
	assign s1 = instr_word[17:15];
	assign s2 = instr_word[14:12];
	assign io = tk && op == iex_pkg::OP_IO;
	// Carry out of bit 23 folds back in
	assign raw    = {1'b0, acc_reg} + {1'b0, mem_word};
	assign oc_sum = raw[23:0] + {23'h000000, raw[24]};

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	halt_entry_a: assert property (
		tk && op == iex_pkg::OP_HALT && s1 == 3'h0 |=> halted && pc_reg == $past(instr_word[14:0])
	) else $error("halt missed its target");
	halt_hold_a: assert property (
		halted && !restart |=> halted && !instr_ready && $stable(pc_reg)
	) else $error("halt did not hold");
	add_word_a: assert property (
		tk && op == iex_pkg::OP_ADD |=> acc_reg == $past(oc_sum)
	) else $error("storage add wrong");
	load_sign_a: assert property (
		tk && op == iex_pkg::OP_ENTER && s1 == 3'h4 |=> acc_reg == {{9{$past(instr_word[14])}}, $past(instr_word[14:0])}
	) else $error("signed load wrong");
	conn_send_a: assert property (
		io && s1 == iex_pkg::SUB_CONN && !chan_busy[chan_addr]
		|=> conn_strobe_reg && conn_code_reg == $past(instr_word[11:0]) && pc_reg == $past(pc_reg) + 15'h0002
	) else $error("connect not sent");
	conn_reject_a: assert property (
		io && s1 == iex_pkg::SUB_CONN && chan_busy[chan_addr] |=> !conn_strobe_reg && pc_reg == $past(pc_reg) + 15'h0001
	) else $error("busy connect not rejected");
	strobe_cause_a: assert property (
		conn_strobe_reg |-> $past(io && s1 == iex_pkg::SUB_CONN && !chan_busy[chan_addr])
	) else $error("stray connect strobe");
	interrupt_enable_op_hold_a: assert property (
		io && s1 == iex_pkg::SUB_GRP7 && s2 == iex_pkg::SUB_INTERRUPT_ENABLE_OP |=> int_enable_reg && !int_take
	) else $error("interrupt taken too early");
	interrupt_disable_op_off_a: assert property (
		io && s1 == iex_pkg::SUB_GRP7 && s2 == iex_pkg::SUB_INTERRUPT_DISABLE_OP |=> !int_enable_reg && !int_take
	) else $error("interrupts still enabled");
	fault_clear_a: assert property (
		io && s1 == iex_pkg::SUB_GRP5 && s2 == iex_pkg::SUB_FCLR && fault_set == 12'h000
		|=> fault_reg == ($past(fault_reg) & ~$past(instr_word[11:0]))
	) else $error("fault clear wrong");
endmodule

bind iex_exec iex_exec_chk #(.CH_N(CH_N)) i_chk (
	.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
	.mem_word(mem_word), .restart(restart), .chan_busy(chan_busy), .fault_set(fault_set),
	.instr_ready(instr_ready), .chan_addr(chan_addr), .pc_reg(pc_reg), .acc_reg(acc_reg),
	.halted(halted), .conn_code_reg(conn_code_reg), .conn_strobe_reg(conn_strobe_reg),
	.fault_reg(fault_reg), .int_enable_reg(int_enable_reg), .int_take(int_take)
);

/* testbench/tb_instruction_exec_a_to_i.sv */
`timescale 1ns/10ps
module tb_instruction_exec_a_to_i;
	logic        core_clk;
	logic        nrst;
	logic        instr_valid;
	logic [23:0] instr_word;
	logic [23:0] mem_word;
	logic [23:0] mem_word2;
	logic [47:0] bcd_field;
	logic [3:0]  len_count;
	logic        restart;
	logic [7:0]  chan_busy;
	logic [11:0] ext_status;
	logic [11:0] int_status;
	logic [11:0] int_lines;
	logic [11:0] int_mask;
	logic [11:0] fault_set;
	logic        instr_ready;
	logic [2:0]  chan_addr;
	logic [14:0] pc_reg;
	logic [23:0] acc_reg;
	logic [23:0] aux_reg;
	logic [47:0] bcd_reg;
	logic [44:0] index_reg;
	logic        halted;
	logic [11:0] conn_code_reg;
	logic [2:0]  conn_chan_reg;
	logic        conn_strobe_reg;
	logic [11:0] fault_reg;
	logic        int_enable_reg;
	logic        int_take;
	int          mismatches;
	int          checked;

	iex_exec #(.CH_N(8)) i_dut (
		.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
		.mem_word(mem_word), .mem_word2(mem_word2), .bcd_field(bcd_field), .len_count(len_count),
		.restart(restart), .chan_busy(chan_busy), .ext_status(ext_status), .int_status(int_status),
		.int_lines(int_lines), .int_mask(int_mask), .fault_set(fault_set), .instr_ready(instr_ready),
		.chan_addr(chan_addr), .pc_reg(pc_reg), .acc_reg(acc_reg), .aux_reg(aux_reg), .bcd_reg(bcd_reg),
		.index_reg(index_reg), .bcd_ovf_reg(), .halted(halted), .conn_code_reg(conn_code_reg),
		.conn_chan_reg(conn_chan_reg), .conn_strobe_reg(conn_strobe_reg), .fault_reg(fault_reg),
		.int_enable_reg(int_enable_reg), .int_take(int_take)
	);

	iex_chan_model #(.CH_N(8)) i_chan (
		.core_clk(core_clk), .nrst(nrst), .conn_strobe_reg(conn_strobe_reg), .conn_chan_reg(conn_chan_reg),
		.conn_code_reg(conn_code_reg), .chan_addr(chan_addr), .chan_busy(chan_busy), .ext_status(ext_status)
	);

	always #20 core_clk = ~core_clk;

	function automatic logic [23:0] iw(input logic [5:0] op, input logic [2:0] s, input logic [14:0] y);
		return {op, s, y};
	endfunction

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Step 0 means jump to the address field, a negative step means no advance
	task automatic ex(input logic [23:0] w, input logic [23:0] m, input int step);
		logic [14:0] p;
		logic [14:0] e;
		@(negedge core_clk);
		p = pc_reg;
		instr_valid = 1'b1;
		instr_word = w;
		mem_word = m;
		@(negedge core_clk);
		instr_valid = 1'b0;
		e = (step < 0) ? p : (step == 0) ? w[14:0] : p + step[14:0];
		chk(pc_reg, e);
	endtask

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask

	task give_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge core_clk);
		mismatches++;
		give_verdict;
	end

	initial begin
		core_clk = 1'b0;
		nrst = 1'b0;
		instr_valid = 1'b0;
		instr_word = 24'h000000;
		mem_word = 24'h000000;
		mem_word2 = 24'h000000;
		bcd_field = 48'h000000000000;
		len_count = 4'h1;
		restart = 1'b0;
		int_status = 12'h000;
		int_lines = 12'h000;
		int_mask = 12'h000;
		fault_set = 12'h000;
		mismatches = 0;
		checked = 0;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		nrst = 1'b1;
		chk(acc_reg, 24'h000000);
		chk(halted, 1'b0);
		chk(instr_ready, 1'b1);
		done("reset");
		ex(iw(iex_pkg::OP_ENTER, 3'h6, 15'h7FFF), 24'h000000, 1);
		chk(acc_reg, 24'h007FFF);
		ex(iw(iex_pkg::OP_ENTER, 3'h4, 15'h7FFF), 24'h000000, 1);
		chk(acc_reg, 24'hFFFFFF);
		ex(iw(iex_pkg::OP_ENTER, 3'h5, 15'h4000), 24'h000000, 1);
		chk(aux_reg, 24'hFFC000);
		ex(iw(iex_pkg::OP_AND, 3'h4, 15'h4001), 24'h000000, 1);
		chk(acc_reg, 24'hFFC001);
		ex(iw(iex_pkg::OP_AND, 3'h6, 15'h7FFF), 24'h000000, 1);
		chk(acc_reg, 24'h004001);
		ex(iw(iex_pkg::OP_AND, 3'h7, 15'h7FFF), 24'h000000, 1);
		chk(aux_reg, 24'h004000);
		ex(iw(iex_pkg::OP_ENTER_CHAR_ADDRESS, 3'h6, 15'h0000), 24'h000000, 1);
		chk(acc_reg, 24'hFF0000);
		ex(iw(iex_pkg::OP_ENTER_CHAR_ADDRESS, 3'h2, 15'h0000), 24'h000000, 1);
		chk(acc_reg, 24'h010000);
		done("immediates");
		for (int s = 0; s < 8; s++) begin
			ex(iw(iex_pkg::OP_JUMP, s[2:0], 15'h0200), 24'h000000, (s % 4 == 1 || s % 4 == 2) ? 0 : 1);
		end
		ex(iw(iex_pkg::OP_ENTER, 3'h4, 15'h7FFE), 24'h000000, 1);
		ex(iw(iex_pkg::OP_SKE, 3'h6, 15'h7FFE), 24'h000000, 2);
		ex(iw(iex_pkg::OP_SKE, 3'h4, 15'h3FFE), 24'h000000, 1);
		ex(iw(iex_pkg::OP_SKG, 3'h6, 15'h7000), 24'h000000, 1);
		ex(iw(iex_pkg::OP_SKG, 3'h4, 15'h7000), 24'h000000, 2);
		done("branches");
		ex(iw(iex_pkg::OP_ADD, 3'h0, 15'h0000), 24'h000002, 1);
		chk(acc_reg, 24'h000001);
		ex(iw(iex_pkg::OP_REGADD, 3'h0, 15'h4000), 24'h000000, 1);
		chk(acc_reg, 24'h004001);
		ex(iw(iex_pkg::OP_REGADD, 3'h6, 15'h4000), 24'h000000, 1);
		ex(iw(iex_pkg::OP_REGADD, 3'h6, 15'h4000), 24'h000000, 1);
		chk(index_reg[29:15], 15'h0003);
		ex(iw(iex_pkg::OP_ENTER, 3'h6, 15'h0007), 24'h000000, 1);
		ex(iw(iex_pkg::OP_DIV, 3'h0, 15'h0000), 24'h000002, 1);
		chk({aux_reg, acc_reg}, 48'h000001000003);
		ex(iw(iex_pkg::OP_DDIV, 3'h0, 15'h0000), 24'h000000, 1);
		chk({acc_reg, 12'h000, fault_reg}, 48'h000003000001);
		done("arithmetic");
		bcd_field = 48'h123000000000;
		len_count = 4'h3;
		ex(iw(iex_pkg::OP_EJUMP, 3'h4, 15'h0300), 24'h000000, 0);
		ex(iw(iex_pkg::OP_BCDADD, 3'h0, 15'h0000), 24'h000000, 1);
		chk(bcd_reg, 48'h000000000123);
		ex(iw(iex_pkg::OP_EJUMP, 3'h4, 15'h0300), 24'h000000, 1);
		ex(iw(iex_pkg::OP_EJUMP, 3'h6, 15'h0300), 24'h000000, 1);
		done("bcd");
		ex(iw(iex_pkg::OP_IO, 3'h0, 15'h2A5C), 24'h000000, 2);
		chk({conn_strobe_reg, conn_code_reg}, 13'h1A5C);
		ex(iw(iex_pkg::OP_IO, 3'h0, 15'h2A5C), 24'h000000, 1);
		chk(conn_strobe_reg, 1'b0);
		int_mask = 12'h300;
		ex(iw(iex_pkg::OP_IO, 3'h2, 15'h2000), 24'h000000, 1);
		chk(acc_reg, 24'h300A5C);
		ex(iw(iex_pkg::OP_IO, 3'h2, 15'h2004), 24'h000000, 1);
		ex(iw(iex_pkg::OP_IO, 3'h2, 15'h2001), 24'h000000, 2);
		int_lines = 12'h400;
		ex(iw(iex_pkg::OP_IO, 3'h4, 15'h2000), 24'h000000, 2);
		int_lines = 12'h100;
		ex(iw(iex_pkg::OP_IO, 3'h4, 15'h2000), 24'h000000, 1);
		done("channel");
		ex(iw(iex_pkg::OP_IO, 3'h7, 15'h4000), 24'h000000, 1);
		chk(int_take, 1'b0);
		ex(iw(iex_pkg::OP_ENTER, 3'h6, 15'h0000), 24'h000000, 1);
		chk(int_take, 1'b1);
		ex(iw(iex_pkg::OP_IO, 3'h7, 15'h3000), 24'h000000, 1);
		chk({int_take, int_enable_reg}, 2'b00);
		fault_set = 12'h0F0;
		@(negedge core_clk);
		fault_set = 12'h000;
		chk(fault_reg, 12'h0F1);
		ex(iw(iex_pkg::OP_IO, 3'h5, 15'h0011), 24'h000000, 1);
		chk(fault_reg, 12'h0E0);
		done("interrupts");
		ex(iw(iex_pkg::OP_HALT, 3'h0, 15'h0123), 24'h000000, 0);
		chk({halted, instr_ready}, 2'b10);
		ex(iw(iex_pkg::OP_ENTER, 3'h6, 15'h0055), 24'h000000, -1);
		chk(acc_reg, 24'h000000);
		restart = 1'b1;
		@(negedge core_clk);
		restart = 1'b0;
		chk(halted, 1'b0);
		ex(iw(iex_pkg::OP_ENTER, 3'h6, 15'h0055), 24'h000000, 1);
		chk(acc_reg, 24'h000055);
		done("halt");
		give_verdict;
	end
endmodule
